// file: design/spd_eeprom_consts.svh
// Constants of the presence-detect EEPROM serial slave: offsets, fields, resets, timing.
// Assumes it is included by bare name into every file that needs a number.
// What this block does
// - Power-on reset and loss of supply-good both force the control logic to reset; supply loss spares the pin synchronizers.
// - Address preamble 1010 means memory command, 0110 means utility command.
// - Memory commands respond only when address bits 3..1 match select pins.
// - Address bit 0 set means read from device, clear means write.
// - Matching address and each written byte get acknowledge in ninth clock.
// - Device transmits until master withholds acknowledge, then waits for STOP.
// - START is falling data with clock high; nothing answered before START.
// - STOP is rising data with clock high and ends the command.
// - Data pin is open drain: low drives zero, release gives one.
// - Utility write codes 001,100,101,000 set protection of blocks 0 to 3.
// - Utility write code 011 clears protection of all four blocks.
// - Utility read codes 001,100,101,000 query protection of blocks 0 to 3.
// - Utility 1100 selects lower bank, 1110 upper, 1101 queries; others reserved.
// - Without high voltage on select pin 0, protection commands nack third byte.
// - Power-up sets address pointer to 00h and lower bank active.
// - One bank active; select commands switch it, query reports it.
// - Byte write: address, byte address, data, STOP; write cycle starts on STOP.
// - Byte address upper nibble picks page, lower nibble byte; 16 bytes per cycle.
// - In-page position increments and wraps in 16-byte buffer; write after STOP.
// - Queries return no data: ack when flag clear or bank 0, else nack.
// - Slave address is not acknowledged while a write cycle runs.
// - Write-protect pin sampled before first data byte; high rejects the write.
// - Reads increment the pointer and wrap inside the active bank.
`ifndef SPD_EEPROM_CONSTS_SVH
`define SPD_EEPROM_CONSTS_SVH
`define PREAMBLE_MEMORY 4'ha
`define PREAMBLE_UTILITY 4'h6
`define UTIL_BLOCK0 3'h1
`define UTIL_BLOCK1 3'h4
`define UTIL_BLOCK2 3'h5
`define UTIL_BLOCK3 3'h0
`define UTIL_CLEAR_ALL 3'h3
`define UTIL_LOWER_BANK 3'h6
`define UTIL_UPPER_BANK 3'h7
`define REG_STATUS 4'h0
`define REG_CONTROL 4'h4
`define CTRL_ACK_AFTER_BANK_SELECT 0
`define CONTROL_RESET 1'h0
`define POINTER_RESET 8'h00
`define WRITE_TIME_US 4000
`define CLOCK_MHZ 10
`define MEM_ADDR_W 9
`endif

// file: design/spd_eeprom_pkg.sv
// Types used only by the serial slave: bus states and commands.
// Assumes the consts header supplies the numbers.
package spd_eeprom_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RX = 3'b001,
      ST_ACK = 3'b010,
      ST_TX = 3'b011,
      ST_MACK = 3'b100
   } state_t;
   typedef enum logic [2:0] {
      CMD_NONE = 3'b000,
      CMD_MEMORY = 3'b001,
      CMD_PROTECT = 3'b010,
      CMD_CLEAR = 3'b011,
      CMD_BANK = 3'b100,
      CMD_QUERY = 3'b101
   } cmd_t;
endpackage

// file: design/mem_port_if.sv
// Port between the serial slave and its byte array.
// Assumes both ends run on one clock.
`timescale 1ns/1ns
interface mem_port_if;
   logic we;
   logic [8:0] waddr;
   logic [7:0] wdata;
   logic [8:0] raddr;
   logic [7:0] rdata;
   modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
   modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// file: design/spd_byte_array.sv
// Byte array of both banks, 512 bytes, registered read data.
// Assumes writes come only from the write-cycle engine.
`timescale 1ns/1ns
module spd_byte_array (
   // Clock
   input wire logic i_clk,
   // Access port
   mem_port_if.mem port
);
   logic [7:0] cells [0:511];
   always_ff @(posedge i_clk) begin
      if (port.we) begin
         cells[port.waddr] <= port.wdata;
      end
   end
   always_ff @(posedge i_clk) begin
      port.rdata <= cells[port.raddr];
   end
endmodule // spd_byte_array

// file: design/spd_eeprom_serial_slave.sv
// Two-wire serial slave of a two-bank presence-detect EEPROM.
// Assumes bus pins, select pins and supply-good arrive asynchronously to i_clk.
`timescale 1ns/1ns
`include "spd_eeprom_consts.svh"
module spd_eeprom_serial_slave #(
   parameter int WRITE_CYCLE_CYCLES = `WRITE_TIME_US * `CLOCK_MHZ
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_power_good,
   // Serial bus
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe,
   // Select and protect pins
   input wire logic i_select_pin_zero,
   input wire logic i_select_pin_one,
   input wire logic i_select_pin_two,
   input wire logic i_high_voltage_indication,
   input wire logic i_write_protect,
   // Register port
   input wire logic [3:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [31:0] o_reg_rdata,
   // Status
   output logic o_busy,
   output logic o_active_bank
);
   logic [7:0] pin_s1;
   logic [7:0] pin_s2;
   logic scl_d;
   logic sda_d;
   logic rst;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   spd_eeprom_pkg::state_t state;
   spd_eeprom_pkg::cmd_t cmd;
   logic [3:0] bit_cnt;
   logic [7:0] shift;
   logic [7:0] tx_byte;
   logic [7:0] byte_num;
   logic is_read;
   logic acked;
   logic [1:0] target_block;
   logic seq_ok;
   logic wp_latched;
   logic [7:0] pointer;
   logic [3:0] page;
   logic [3:0] pos;
   logic [7:0] page_buf [0:15];
   logic [15:0] page_mask;
   logic write_pending;
   logic commit_req;
   logic [3:0] prot;
   logic bank;
   logic target_bank;
   logic control_ack;
   logic [4:0] commit_idx;
   logic [31:0] busy_cnt;
   logic ack_now;
   spd_eeprom_pkg::cmd_t next_cmd;
   logic [1:0] next_block;
   logic next_bank;
   mem_port_if mport ();

   spd_byte_array array (
      .i_clk(i_clk),
      .port(mport.mem)
   );

   // Pins: 0 scl, 1 sda, 2..4 select, 5 high voltage, 6 write protect, 7 supply good.
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         pin_s1 <= 8'h03;
         pin_s2 <= 8'h03;
      end else begin
         pin_s1 <= {i_power_good, i_write_protect, i_high_voltage_indication,
                    i_select_pin_two, i_select_pin_one, i_select_pin_zero, i_sda, i_scl};
         pin_s2 <= pin_s1;
      end
   end

   // Losing supply good resets everything the reset pin does except the pin synchronizers, so brown-outs leave no stale state.
   assign rst = !i_reset_n || !pin_s2[7];

   always_ff @(posedge i_clk) begin
      if (rst) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= pin_s2[0];
         sda_d <= pin_s2[1];
      end
   end

   assign scl_rise = pin_s2[0] && !scl_d;
   assign scl_fall = !pin_s2[0] && scl_d;
   assign start_seen = pin_s2[0] && scl_d && sda_d && !pin_s2[1];
   assign stop_seen = pin_s2[0] && scl_d && !sda_d && pin_s2[1];

   // Utility code decode; reserved encodings come back as CMD_NONE.
   function automatic spd_eeprom_pkg::cmd_t util_decode(input logic [3:0] code);
      spd_eeprom_pkg::cmd_t c;
      c = spd_eeprom_pkg::CMD_NONE;
      case (code[3:1])
         `UTIL_BLOCK0, `UTIL_BLOCK1, `UTIL_BLOCK2, `UTIL_BLOCK3: begin
            c = code[0] ? spd_eeprom_pkg::CMD_QUERY : spd_eeprom_pkg::CMD_PROTECT;
         end
         `UTIL_CLEAR_ALL: begin
            c = code[0] ? spd_eeprom_pkg::CMD_NONE : spd_eeprom_pkg::CMD_CLEAR;
         end
         `UTIL_LOWER_BANK: begin
            c = code[0] ? spd_eeprom_pkg::CMD_QUERY : spd_eeprom_pkg::CMD_BANK;
         end
         `UTIL_UPPER_BANK: begin
            c = code[0] ? spd_eeprom_pkg::CMD_NONE : spd_eeprom_pkg::CMD_BANK;
         end
         default: begin
            c = spd_eeprom_pkg::CMD_NONE;
         end
      endcase
      return c;
   endfunction

   // Block number from a utility code: 001 -> 0, 100 -> 1, 101 -> 2, 000 -> 3.
   function automatic logic [1:0] block_of(input logic [2:0] code);
      logic [1:0] b;
      b = 2'h3;
      if (code == `UTIL_BLOCK0) begin
         b = 2'h0;
      end else if (code == `UTIL_BLOCK1) begin
         b = 2'h1;
      end else if (code == `UTIL_BLOCK2) begin
         b = 2'h2;
      end
      return b;
   endfunction

   // Acknowledge decision for the byte just shifted in, made at the eighth falling edge.
   always_comb begin
      ack_now = 1'b0;
      next_cmd = cmd;
      next_block = target_block;
      next_bank = target_bank;
      if (byte_num == 8'h00) begin
         next_block = block_of(shift[3:1]);
         next_bank = shift[1];
         next_cmd = spd_eeprom_pkg::CMD_NONE;
         if (shift[7:4] == `PREAMBLE_MEMORY) begin
            if (shift[3:1] == pin_s2[4:2]) begin
               next_cmd = spd_eeprom_pkg::CMD_MEMORY;
            end
         end else if (shift[7:4] == `PREAMBLE_UTILITY) begin
            next_cmd = util_decode(shift[3:0]);
         end
         if (o_busy) begin
            next_cmd = spd_eeprom_pkg::CMD_NONE;
         end
         if (next_cmd == spd_eeprom_pkg::CMD_QUERY) begin
            if (shift[3:1] == `UTIL_LOWER_BANK) begin
               ack_now = !bank;
            end else begin
               ack_now = !prot[next_block];
            end
         end else if (next_cmd == spd_eeprom_pkg::CMD_PROTECT) begin
            ack_now = !prot[next_block];
         end else begin
            ack_now = next_cmd != spd_eeprom_pkg::CMD_NONE;
         end
      end else if (!is_read) begin
         if (byte_num == 8'h01) begin
            ack_now = 1'b1;
         end else if (cmd == spd_eeprom_pkg::CMD_MEMORY) begin
            // Protection is judged on the block the data will land in.
            ack_now = !wp_latched && !prot[{bank, pointer[7]}];
         end else if (byte_num == 8'h02) begin
            if (cmd == spd_eeprom_pkg::CMD_BANK) begin
               ack_now = control_ack;
            end else begin
               ack_now = pin_s2[5];
            end
         end
      end
   end

   // Bus protocol engine.
   always_ff @(posedge i_clk) begin
      if (rst) begin
         state <= spd_eeprom_pkg::ST_IDLE;
         cmd <= spd_eeprom_pkg::CMD_NONE;
         bit_cnt <= 4'h0;
         shift <= 8'h00;
         tx_byte <= 8'h00;
         byte_num <= 8'h00;
         is_read <= 1'b0;
         acked <= 1'b0;
         target_block <= 2'h0;
         target_bank <= 1'b0;
         seq_ok <= 1'b0;
         wp_latched <= 1'b0;
         pointer <= `POINTER_RESET;
         page <= 4'h0;
         pos <= 4'h0;
         page_mask <= 16'h0000;
         write_pending <= 1'b0;
         commit_req <= 1'b0;
         o_sda_oe <= 1'b0;
         o_sda_out <= 1'b0;
      end else begin
         commit_req <= 1'b0;
         if (start_seen) begin
            state <= spd_eeprom_pkg::ST_RX;
            bit_cnt <= 4'h0;
            byte_num <= 8'h00;
            seq_ok <= 1'b0;
            o_sda_oe <= 1'b0;
         end else if (stop_seen) begin
            state <= spd_eeprom_pkg::ST_IDLE;
            o_sda_oe <= 1'b0;
            if (write_pending) begin
               commit_req <= 1'b1;
               write_pending <= 1'b0;
            end
         end else begin
            unique case (state)
               spd_eeprom_pkg::ST_IDLE: begin
                  o_sda_oe <= 1'b0;
               end
               spd_eeprom_pkg::ST_RX: begin
                  if (scl_rise) begin
                     shift <= {shift[6:0], pin_s2[1]};
                     bit_cnt <= bit_cnt + 4'h1;
                  end else if (scl_fall && bit_cnt == 4'h8) begin
                     state <= spd_eeprom_pkg::ST_ACK;
                     acked <= ack_now;
                     o_sda_oe <= ack_now;
                     cmd <= next_cmd;
                     target_block <= next_block;
                     target_bank <= next_bank;
                     if (byte_num == 8'h00) begin
                        is_read <= shift[0];
                        if (next_cmd == spd_eeprom_pkg::CMD_MEMORY && !shift[0]) begin
                           page_mask <= 16'h0000;
                        end
                     end else if (byte_num == 8'h01 && cmd == spd_eeprom_pkg::CMD_MEMORY) begin
                        pointer <= shift;
                        page <= shift[7:4];
                        pos <= shift[3:0];
                     end else if (cmd == spd_eeprom_pkg::CMD_MEMORY && ack_now) begin
                        page_buf[pos] <= shift;
                        page_mask[pos] <= 1'b1;
                        pos <= pos + 4'h1;
                        write_pending <= 1'b1;
                     end else if (byte_num == 8'h02) begin
                        seq_ok <= ack_now || cmd == spd_eeprom_pkg::CMD_BANK;
                     end
                  end
               end
               spd_eeprom_pkg::ST_ACK: begin
                  if (scl_fall) begin
                     o_sda_oe <= 1'b0;
                     bit_cnt <= 4'h0;
                     byte_num <= byte_num + 8'h01;
                     if (byte_num == 8'h01) begin
                        wp_latched <= pin_s2[6];
                     end
                     if (!acked) begin
                        state <= spd_eeprom_pkg::ST_IDLE;
                     end else if (is_read && cmd == spd_eeprom_pkg::CMD_MEMORY) begin
                        state <= spd_eeprom_pkg::ST_TX;
                        tx_byte <= mport.rdata;
                        o_sda_oe <= !mport.rdata[7];
                     end else if (is_read) begin
                        state <= spd_eeprom_pkg::ST_IDLE;
                     end else begin
                        state <= spd_eeprom_pkg::ST_RX;
                     end
                  end
               end
               spd_eeprom_pkg::ST_TX: begin
                  if (scl_rise) begin
                     bit_cnt <= bit_cnt + 4'h1;
                  end else if (scl_fall) begin
                     if (bit_cnt == 4'h8) begin
                        o_sda_oe <= 1'b0;
                        state <= spd_eeprom_pkg::ST_MACK;
                        pointer <= pointer + 8'h01;
                     end else begin
                        o_sda_oe <= !tx_byte[3'h7 - bit_cnt[2:0]];
                     end
                  end
               end
               spd_eeprom_pkg::ST_MACK: begin
                  if (scl_rise) begin
                     // A withheld acknowledge ends transmission until the next START.
                     acked <= !pin_s2[1];
                  end else if (scl_fall) begin
                     bit_cnt <= 4'h0;
                     if (acked) begin
                        state <= spd_eeprom_pkg::ST_TX;
                        tx_byte <= mport.rdata;
                        o_sda_oe <= !mport.rdata[7];
                     end else begin
                        state <= spd_eeprom_pkg::ST_IDLE;
                     end
                  end
               end
               default: begin
                  state <= spd_eeprom_pkg::ST_IDLE;
               end
            endcase
         end
      end
   end

   // Protection flags and active bank change only when the whole sequence ended in STOP.
   always_ff @(posedge i_clk) begin
      if (rst) begin
         prot <= 4'h0;
         bank <= 1'b0;
      end else if (stop_seen && seq_ok && !is_read) begin
         if (cmd == spd_eeprom_pkg::CMD_PROTECT) begin
            prot[target_block] <= 1'b1;
         end else if (cmd == spd_eeprom_pkg::CMD_CLEAR) begin
            prot <= 4'h0;
         end else if (cmd == spd_eeprom_pkg::CMD_BANK) begin
            bank <= target_bank;
         end
      end
   end

   // Write cycle: copy marked buffer bytes while busy holds for the programmed time.
   always_ff @(posedge i_clk) begin
      if (rst) begin
         o_busy <= 1'b0;
         commit_idx <= 5'h00;
         busy_cnt <= 32'h0;
      end else if (commit_req || (stop_seen && seq_ok && !is_read &&
                   (cmd == spd_eeprom_pkg::CMD_PROTECT || cmd == spd_eeprom_pkg::CMD_CLEAR))) begin
         o_busy <= 1'b1;
         commit_idx <= commit_req ? 5'h00 : 5'h10;
         busy_cnt <= 32'(WRITE_CYCLE_CYCLES);
      end else if (o_busy) begin
         if (!commit_idx[4]) begin
            commit_idx <= commit_idx + 5'h01;
         end
         if (busy_cnt <= 32'h1) begin
            o_busy <= 1'b0;
         end else begin
            busy_cnt <= busy_cnt - 32'h1;
         end
      end
   end

   assign mport.we = o_busy && !commit_idx[4] && page_mask[commit_idx[3:0]];
   assign mport.waddr = {bank, page, commit_idx[3:0]};
   assign mport.wdata = page_buf[commit_idx[3:0]];
   assign mport.raddr = {bank, pointer};

   // Register port: status is read-only, control picks the answer after a bank select.
   always_ff @(posedge i_clk) begin
      if (rst) begin
         control_ack <= `CONTROL_RESET;
         o_reg_rdata <= 32'h0;
      end else begin
         if (i_reg_wr && i_reg_addr == `REG_CONTROL) begin
            control_ack <= i_reg_wdata[`CTRL_ACK_AFTER_BANK_SELECT];
         end
         o_reg_rdata <= 32'h0;
         if (i_reg_rd && i_reg_addr == `REG_STATUS) begin
            o_reg_rdata <= {26'h0, bank, o_busy, prot};
         end else if (i_reg_rd && i_reg_addr == `REG_CONTROL) begin
            o_reg_rdata <= {31'h0, control_ack};
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (rst) begin
         o_active_bank <= 1'b0;
      end else begin
         o_active_bank <= bank;
      end
   end
endmodule // spd_eeprom_serial_slave

// file: test/two_wire_master.sv
// Behavioural bus master for the serial slave: clock, data and framing.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ns
module two_wire_master (
   // Clock
   input wire logic i_clk,
   // Bus
   input wire logic i_sda_line,
   output logic o_scl,
   output logic o_sda_low
);
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   task automatic q();
      repeat (2) @(posedge i_clk);
   endtask
   // The clock stands high between frames; the data line is raised before the clock.
   task automatic start();
      o_sda_low <= 1'b0;
      q();
      o_scl <= 1'b1;
      q();
      o_sda_low <= 1'b1;
      q();
      o_scl <= 1'b0;
      q();
   endtask
   task automatic stop();
      o_sda_low <= 1'b1;
      q();
      o_scl <= 1'b1;
      q();
      o_sda_low <= 1'b0;
      q();
   endtask
   // Nine bits, most significant first; the ninth is the acknowledge slot.
   task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r,
                       output logic ack);
      logic [8:0] w;
      logic [8:0] s;
      w = {d, last};
      for (int i = 8; i >= 0; i--) begin
         o_sda_low <= !w[i];
         q();
         o_scl <= 1'b1;
         q();
         s[i] = i_sda_line;
         q();
         o_scl <= 1'b0;
         q();
      end
      r = s[8:1];
      ack = !s[0];
   endtask
endmodule // two_wire_master

// file: test/spd_eeprom_serial_slave_asserts.sv
// Concurrent checks on the serial slave's top-level ports.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ns
module spd_eeprom_serial_slave_asserts #(
   parameter int WRITE_CYCLE_CYCLES = 40000
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_power_good,
   // Serial bus
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic o_sda_out,
   input wire logic o_sda_oe,
   // Register port and status
   input wire logic [3:0] i_reg_addr,
   input wire logic i_reg_rd,
   input wire logic [31:0] o_reg_rdata,
   input wire logic o_busy,
   input wire logic o_active_bank
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n || !i_power_good);
   int busy_run;
   // A counter keeps the long write time out of the repetition operators.
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         busy_run <= 0;
      end else begin
         busy_run <= o_busy ? busy_run + 1 : 0;
      end
   end
   property p_open_drain;
      o_sda_oe |-> !o_sda_out;
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("data pin driven high");
   property p_reset_quiet;
      disable iff (!i_power_good) !i_reset_n |=> !o_sda_oe && !o_busy && !o_active_bank;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("outputs not cleared by reset");
   property p_power_loss;
      disable iff (!i_reset_n)
      $fell(i_power_good) ##1 !i_power_good [*3] |=> !o_active_bank && !o_busy && !o_sda_oe;
   endproperty
   a_power_loss: assert property (p_power_loss)
      else $error("supply loss did not reset");
   property p_ack_hold;
      $rose(o_sda_oe) |=> o_sda_oe [*4];
   endproperty
   a_ack_hold: assert property (p_ack_hold)
      else $error("drive released too early");
   property p_drive_clock_low;
      $rose(o_sda_oe) |-> !i_scl;
   endproperty
   a_drive_clock_low: assert property (p_drive_clock_low)
      else $error("drive began with clock high");
   property p_busy_len;
      $fell(o_busy) |-> busy_run == WRITE_CYCLE_CYCLES;
   endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("write cycle length wrong");
   property p_busy_stop;
      $rose(o_busy) |-> i_scl && i_sda;
   endproperty
   a_busy_stop: assert property (p_busy_stop)
      else $error("write cycle began without stop");
   property p_busy_quiet;
      o_busy |-> !o_sda_oe;
   endproperty
   a_busy_quiet: assert property (p_busy_quiet)
      else $error("answered while busy");
   property p_bank_stop;
      $changed(o_active_bank) |-> i_scl && i_sda;
   endproperty
   a_bank_stop: assert property (p_bank_stop)
      else $error("bank changed outside stop");
   property p_status_bank;
      i_reg_rd && i_reg_addr == 4'h0 |=> o_reg_rdata[5] == $past(o_active_bank);
   endproperty
   a_status_bank: assert property (p_status_bank)
      else $error("status bank bit wrong");
   c_busy: cover property ($rose(o_busy));
   c_bank: cover property ($rose(o_active_bank));
   c_ack: cover property ($rose(o_sda_oe));
endmodule // spd_eeprom_serial_slave_asserts
bind spd_eeprom_serial_slave spd_eeprom_serial_slave_asserts #(
   .WRITE_CYCLE_CYCLES(WRITE_CYCLE_CYCLES)
) u_asserts (
   .i_clk(i_clk), .i_reset_n(i_reset_n), .i_power_good(i_power_good), .i_scl(i_scl),
   .i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_reg_addr(i_reg_addr),
   .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_busy(o_busy),
   .o_active_bank(o_active_bank)
);

// file: test/spd_eeprom_serial_slave_bench.sv
// Self-checking bench for the serial slave with a behavioural bus master.
// Assumes a short write cycle parameter so the run stays brief.
`timescale 1ns/1ns
module spd_eeprom_serial_slave_bench;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic power_good = 1'b1;
   logic hv = 1'b0;
   logic wp = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] rdata;
   logic sda_out, sda_oe, busy, bank, scl, m_low;
   wire sda_line = !(m_low || sda_oe);
   int n_fail = 0;
   int checks_done = 0;
   logic [7:0] rd [0:15];
   logic [2:0] blk [0:3] = '{3'h1, 3'h4, 3'h5, 3'h0};
   localparam logic [7:0] dev_w = 8'haa;
   always #50 clk = ~clk;
   // Select pins stay fixed for the whole run.
   spd_eeprom_serial_slave #(.WRITE_CYCLE_CYCLES(150)) u_dut (
      .i_clk(clk), .i_reset_n(reset_n), .i_power_good(power_good), .i_scl(scl),
      .i_sda(sda_line), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_select_pin_zero(1'b1),
      .i_select_pin_one(1'b0), .i_select_pin_two(1'b1), .i_high_voltage_indication(hv),
      .i_write_protect(wp), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
      .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(rdata), .o_busy(busy),
      .o_active_bank(bank));
   two_wire_master u_m (.i_clk(clk), .i_sda_line(sda_line), .o_scl(scl), .o_sda_low(m_low));
   task automatic finish_test();
      $display("Checks %0d, failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wait_busy(input logic lvl);
      for (int i = 0; i < 400 && busy !== lvl; i++)
         @(posedge clk);
      if (busy !== lvl) begin
         n_fail++;
         finish_test();
      end
   endtask
   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      v = rdata;
   endtask
   task automatic sb(input logic [7:0] d, input logic e);
      logic [7:0] r;
      logic a;
      u_m.xfer(d, 1'b1, r, a);
      chk(32'(a), 32'(e));
   endtask
   task automatic mem_write(input logic [7:0] a, input logic [7:0] d0, input int n,
                            input logic e);
      u_m.start();
      sb(dev_w, 1'b1);
      sb(a, 1'b1);
      for (int i = 0; i < n; i++)
         sb(d0 + 8'(i), e);
      u_m.stop();
      if (e) begin
         wait_busy(1'b1);
         u_m.start();
         sb(dev_w, 1'b0);
         u_m.stop();
         wait_busy(1'b0);
      end
   endtask
   task automatic mem_read(input logic [7:0] a, input int n);
      logic k;
      u_m.start();
      sb(dev_w, 1'b1);
      sb(a, 1'b1);
      u_m.start();
      sb(dev_w | 8'h01, 1'b1);
      for (int i = 0; i < n; i++)
         u_m.xfer(8'hff, i == n - 1, rd[i], k);
      u_m.stop();
   endtask
   task automatic util(input logic [7:0] a, input logic e3, input logic wc);
      u_m.start();
      sb(a, 1'b1);
      sb(8'h00, 1'b1);
      sb(8'h00, e3);
      u_m.stop();
      repeat (4) @(posedge clk);
      if (wc) begin
         wait_busy(1'b1);
         wait_busy(1'b0);
      end
   endtask
   task automatic query(input logic [7:0] a, input logic e);
      u_m.start();
      sb(a, e);
      u_m.stop();
   endtask
   task automatic t_regs();
      logic [31:0] v;
      reg_read(4'h0, v);
      chk(v, 32'h0);
      reg_write(4'h4, 32'h1);
      reg_read(4'h4, v);
      chk(v, 32'h1);
      reg_read(4'h8, v);
      chk(v, 32'h0);
      $display("registers done");
   endtask
   task automatic t_framing();
      sb(dev_w, 1'b0);
      u_m.stop();
      query(8'ha4, 1'b0);
      query(8'h5a, 1'b0);
      $display("framing done");
   endtask
   task automatic t_write();
      mem_write(8'h1e, 8'h40, 18, 1'b1);
      mem_read(8'h10, 16);
      for (int k = 0; k < 16; k++)
         chk(32'(rd[k]), 32'(8'h42 + 8'(k)));
      mem_write(8'hff, 8'h5a, 1, 1'b1);
      mem_write(8'h00, 8'hc3, 1, 1'b1);
      mem_read(8'hff, 2);
      chk(32'(rd[0]), 32'h5a);
      chk(32'(rd[1]), 32'hc3);
      wp <= 1'b1;
      mem_write(8'h20, 8'h11, 1, 1'b0);
      wp <= 1'b0;
      $display("memory done");
   endtask
   task automatic t_protect();
      logic [31:0] v;
      hv <= 1'b1;
      for (int b = 0; b < 4; b++) begin
         query({4'h6, blk[b], 1'b1}, 1'b1);
         util({4'h6, blk[b], 1'b0}, 1'b1, 1'b1);
         query({4'h6, blk[b], 1'b1}, 1'b0);
      end
      reg_read(4'h0, v);
      chk(v, 32'hf);
      mem_write(8'h80, 8'h77, 1, 1'b0);
      hv <= 1'b0;
      util(8'h66, 1'b0, 1'b0);
      query(8'h63, 1'b0);
      hv <= 1'b1;
      util(8'h66, 1'b1, 1'b1);
      reg_read(4'h0, v);
      chk(v, 32'h0);
      hv <= 1'b0;
      $display("protection done");
   endtask
   task automatic t_bank();
      logic [31:0] v;
      util(8'h6e, 1'b1, 1'b0);
      chk(32'(bank), 32'h1);
      query(8'h6d, 1'b0);
      query(8'h6f, 1'b0);
      util(8'h6c, 1'b1, 1'b0);
      chk(32'(bank), 32'h0);
      query(8'h6d, 1'b1);
      util(8'h6e, 1'b1, 1'b0);
      power_good <= 1'b0;
      repeat (4) @(posedge clk);
      power_good <= 1'b1;
      repeat (4) @(posedge clk);
      chk(32'(bank), 32'h0);
      reg_read(4'h4, v);
      chk(v, 32'h0);
      util(8'h6e, 1'b0, 1'b0);
      chk(32'(bank), 32'h1);
      $display("bank done");
   endtask
   initial begin
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      repeat (6) @(posedge clk);
      t_regs();
      t_framing();
      t_write();
      t_protect();
      t_bank();
      finish_test();
   end
endmodule // spd_eeprom_serial_slave_bench
